/* hw/rps_pkg.sv */
// Overview of operation
// - High enable requests rail on, low disables
// - Floating enable reads low via pull-down
// - Low enable keeps rail discharge switched on
// - Supply collapse clears all internal logic state; discharge keeps tracking enable
// - Positive ramp: 40mA guard 2.5ms, then free
// - Target missed at 2.5ms: 230mA limit mode
// - Target reached in fallback: boost-node limit
// - Short detected below 60% of target
// - Short held 10ms: shut down and latch
// - Recovery before 10ms abandons count, no latch
// - Both enables low clear the shutdown latch
// - Host: positive, 5ms, negative, 5ms, load
// - Host: load off, enables low, >1ms gap
// - Host: load after 2.5ms and ramp estimate
// - Each rail switched by its own enable
package rps_pkg;

  // Clock rate in kHz; all counts derive from it.
  localparam int CLK_KHZ = 40000;

  // Documented durations in microseconds.
  localparam int STARTUP_WINDOW_US = 2500;
  localparam int SC_COUNT_US = 10000;
  localparam int SEQ_STEP_US = 5000;
  localparam int RESTART_GAP_US = 1000;

  // Durations as clock cycles; the gap is a least time, so one more cycle.
  localparam int STARTUP_WINDOW_CYC = STARTUP_WINDOW_US * CLK_KHZ / 1000;
  localparam int SC_COUNT_CYC = SC_COUNT_US * CLK_KHZ / 1000;
  localparam int SEQ_STEP_CYC = SEQ_STEP_US * CLK_KHZ / 1000;
  localparam int RESTART_GAP_CYC = RESTART_GAP_US * CLK_KHZ / 1000 + 1;

  // Host register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

  // Control bits.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // Interrupt status bits.
  localparam int IRQ_LOAD_READY_BIT = 0;
  localparam int IRQ_STOPPED_BIT = 1;
  localparam int IRQ_RESTART_OK_BIT = 2;
  localparam int IRQ_W = 3;

  // Reset values.
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0;

  // Positive rail current-limit mode.
  typedef enum logic [1:0] {
    LIM_OFF = 2'b00,
    LIM_GUARD = 2'b01,
    LIM_FALLBACK = 2'b10,
    LIM_BOOST = 2'b11
  } rps_limit_e;

  // Host sequencer state.
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_POS_UP = 3'b001,
    SEQ_NEG_UP = 3'b010,
    SEQ_LOADED = 3'b011,
    SEQ_LOAD_OFF = 3'b100,
    SEQ_GAP = 3'b101
  } rps_seq_e;

endpackage

/* hw/rps_rail_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rps_rail_if;
  // Host drive and drive enable of each enable pin.
  logic pos_en_drv;
  logic pos_en_oe;
  logic neg_en_drv;
  logic neg_en_oe;
  // Pin levels as the device sees them.
  logic positive_rail_enable;
  logic negative_rail_enable;

  // An undriven pin is pulled low inside the device.
  assign positive_rail_enable = pos_en_oe & pos_en_drv;
  assign negative_rail_enable = neg_en_oe & neg_en_drv;

  modport device (input positive_rail_enable, input negative_rail_enable);
  modport host (output pos_en_drv, output pos_en_oe, output neg_en_drv, output neg_en_oe);
endinterface
`default_nettype wire

/* hw/rps_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_timer #(
  parameter int TERM = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic clr,
  input wire logic run,
  // Result.
  output logic done
);

  localparam int W = $clog2(TERM + 1);

  logic [W-1:0] cnt_r;
  logic done_r;

  // Counts cycles while run is held; any drop of run restarts from zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (clr || !run) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (cnt_r == W'(TERM - 1)) begin
        done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign done = done_r;

endmodule // rps_timer
`default_nettype wire

/* hw/rps_device.sv */
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module rps_device #(
  parameter int STARTUP_CYC = rps_pkg::STARTUP_WINDOW_CYC,
  parameter int SC_CYC = rps_pkg::SC_COUNT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the host.
  rps_rail_if.device rail,
  // Analogue comparator levels.
  input wire logic supply_input_low,
  input wire logic pos_at_target,
  input wire logic pos_below_sc,
  input wire logic neg_below_sc,
  // Rail control.
  output logic pos_rail_run,
  output logic neg_rail_run,
  output logic pos_discharge,
  output logic neg_discharge,
  // Current limit of the positive rail.
  output var rps_pkg::rps_limit_e limit_mode,
  // Protection status.
  output logic pos_sc_counting,
  output logic neg_sc_counting,
  output logic pos_sc_fault,
  output logic neg_sc_fault,
  output logic shutdown_latched
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic en_pos;
  logic en_neg;
  logic por_clear;
  logic at_target;
  logic low_pos;
  logic low_neg;

  // Every pin passes two flip-flops; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {neg_below_sc, pos_below_sc, pos_at_target, supply_input_low,
                  rail.negative_rail_enable, rail.positive_rail_enable};
      sync2_r <= sync1_r;
    end
  end

  // Named views of the synchronised pins.
  assign en_pos = sync2_r[0];
  assign en_neg = sync2_r[1];
  assign por_clear = sync2_r[2];
  assign at_target = sync2_r[3];
  assign low_pos = sync2_r[4];
  assign low_neg = sync2_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // Rail switching.

  logic latch_r;
  logic on_pos;
  logic on_neg;

  // Each rail follows its own enable unless the shutdown latch holds it off.
  assign on_pos = en_pos && !latch_r;
  assign on_neg = en_neg && !latch_r;

  logic pos_run_r;
  logic neg_run_r;
  logic pos_dis_r;
  logic neg_dis_r;

  // Run outputs; a supply collapse forces them off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_run_r <= 1'b0;
      neg_run_r <= 1'b0;
    end else if (por_clear) begin
      pos_run_r <= 1'b0;
      neg_run_r <= 1'b0;
    end else begin
      pos_run_r <= on_pos;
      neg_run_r <= on_neg;
    end
  end

  // Discharge is on for as long as the rail's enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_dis_r <= 1'b1;
      neg_dis_r <= 1'b1;
    end else begin
      pos_dis_r <= !en_pos;
      neg_dis_r <= !en_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up current limit of the positive rail.

  rps_pkg::rps_limit_e lim_r;
  rps_pkg::rps_limit_e lim_nxt;
  logic win_done;

  // Window timer starts with the entry into guard, so guard lasts exactly the window.
  rps_timer #(
    .TERM(STARTUP_CYC)
  ) u_window (
    .pclk(pclk),
    .presetn(presetn),
    .clr(por_clear),
    .run(lim_nxt == rps_pkg::LIM_GUARD),
    .done(win_done)
  );

  // Guard first, then free or fallback depending on the target comparator.
  always_comb begin
    lim_nxt = lim_r;
    case (lim_r)
      rps_pkg::LIM_OFF: begin
        if (on_pos) begin
          lim_nxt = rps_pkg::LIM_GUARD;
        end
      end
      rps_pkg::LIM_GUARD: begin
        if (win_done) begin
          lim_nxt = at_target ? rps_pkg::LIM_BOOST : rps_pkg::LIM_FALLBACK;
        end
      end
      rps_pkg::LIM_FALLBACK: begin
        if (at_target) begin
          lim_nxt = rps_pkg::LIM_BOOST;
        end
      end
      rps_pkg::LIM_BOOST: begin
        lim_nxt = rps_pkg::LIM_BOOST;
      end
      default: begin
        lim_nxt = rps_pkg::LIM_OFF;
      end
    endcase
    if (!on_pos) begin
      lim_nxt = rps_pkg::LIM_OFF;
    end
  end

  // Limit mode register, cleared by a supply collapse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_r <= rps_pkg::LIM_OFF;
    end else if (por_clear) begin
      lim_r <= rps_pkg::LIM_OFF;
    end else begin
      lim_r <= lim_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Short-circuit protection of both rails.

  logic det_pos;
  logic det_neg;
  logic sc_done_pos;
  logic sc_done_neg;

  // Detection is the 60 % comparator while the rail is switched on.
  assign det_pos = on_pos && low_pos;
  assign det_neg = on_neg && low_neg;

  // A drop of detection resets the count, so recovery abandons it.
  rps_timer #(
    .TERM(SC_CYC)
  ) u_sc_pos (
    .pclk(pclk),
    .presetn(presetn),
    .clr(por_clear),
    .run(det_pos),
    .done(sc_done_pos)
  );

  // Same count for the negative rail on its own comparator.
  rps_timer #(
    .TERM(SC_CYC)
  ) u_sc_neg (
    .pclk(pclk),
    .presetn(presetn),
    .clr(por_clear),
    .run(det_neg),
    .done(sc_done_neg)
  );

  logic both_off;
  logic pos_flt_r;
  logic neg_flt_r;
  logic pos_cnt_r;
  logic neg_cnt_r;

  assign both_off = !en_pos && !en_neg;

  // Shutdown latch: a full count sets it, both enables low release it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= 1'b0;
    end else if (por_clear) begin
      latch_r <= 1'b0;
    end else if (sc_done_pos || sc_done_neg) begin
      latch_r <= 1'b1;
    end else if (both_off) begin
      latch_r <= 1'b0;
    end
  end

  // Which rail caused the shutdown; held with the latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_flt_r <= 1'b0;
      neg_flt_r <= 1'b0;
    end else if (por_clear) begin
      pos_flt_r <= 1'b0;
      neg_flt_r <= 1'b0;
    end else if (sc_done_pos || sc_done_neg) begin
      pos_flt_r <= pos_flt_r || sc_done_pos;
      neg_flt_r <= neg_flt_r || sc_done_neg;
    end else if (both_off) begin
      pos_flt_r <= 1'b0;
      neg_flt_r <= 1'b0;
    end
  end

  // Counting indicators show that a short is being timed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cnt_r <= 1'b0;
      neg_cnt_r <= 1'b0;
    end else begin
      pos_cnt_r <= det_pos && !por_clear;
      neg_cnt_r <= det_neg && !por_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign pos_rail_run = pos_run_r;
  assign neg_rail_run = neg_run_r;
  assign pos_discharge = pos_dis_r;
  assign neg_discharge = neg_dis_r;
  assign limit_mode = lim_r;
  assign pos_sc_counting = pos_cnt_r;
  assign neg_sc_counting = neg_cnt_r;
  assign pos_sc_fault = pos_flt_r;
  assign neg_sc_fault = neg_flt_r;
  assign shutdown_latched = latch_r;

endmodule // rps_device
`default_nettype wire

/* hw/rps_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_host #(
  parameter int STEP_CYC = rps_pkg::SEQ_STEP_CYC,
  parameter int GAP_CYC = rps_pkg::RESTART_GAP_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt and panel load.
  output logic irq,
  output logic panel_load_enable,
  // Link to the device.
  rps_rail_if.host rail
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  localparam int IRQW = rps_pkg::IRQ_W;

  logic setup;
  logic done;
  logic wr;
  logic rd_irq;
  logic mapped;
  logic [31:0] rdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [IRQW-1:0] stat_r;
  logic [IRQW-1:0] mask_r;
  rps_pkg::rps_seq_e seq_r;
  logic pos_r;
  logic neg_r;
  logic load_r;

  assign setup = psel && !penable;
  assign done = psel && penable && pready_r;
  assign wr = done && pwrite && !pslverr_r;
  assign rd_irq = done && !pwrite && (paddr == rps_pkg::REG_IRQ_STATUS);
  assign mapped = (paddr == rps_pkg::REG_CTRL) || (paddr == rps_pkg::REG_STATUS) ||
                  (paddr == rps_pkg::REG_IRQ_STATUS) || (paddr == rps_pkg::REG_IRQ_MASK);

  // Read data chosen by address; unmapped reads return zero.
  always_comb begin
    rdata_nxt = 32'h0;
    case (paddr)
      rps_pkg::REG_STATUS: rdata_nxt = {26'h0, load_r, neg_r, pos_r, seq_r};
      rps_pkg::REG_IRQ_STATUS: rdata_nxt = {29'h0, stat_r};
      rps_pkg::REG_IRQ_MASK: rdata_nxt = {29'h0, mask_r};
      default: rdata_nxt = 32'h0;
    endcase
  end

  // No wait state: answer prepared in setup, ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= rps_pkg::RDATA_RST;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= !mapped;
        prdata_r <= pwrite ? 32'h0 : rdata_nxt;
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= rps_pkg::IRQ_MASK_RST;
    end else if (wr && paddr == rps_pkg::REG_IRQ_MASK) begin
      mask_r <= pwdata[IRQW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer.

  logic start_req;
  logic stop_req;
  logic [18:0] wait_r;
  logic [IRQW-1:0] ev;

  assign start_req = wr && paddr == rps_pkg::REG_CTRL && pwdata[rps_pkg::CTRL_START_BIT];
  assign stop_req = wr && paddr == rps_pkg::REG_CTRL && pwdata[rps_pkg::CTRL_STOP_BIT];

  // Start only from idle; stop from any powered state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= rps_pkg::SEQ_IDLE;
      wait_r <= 19'h0;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      if (wait_r != 19'h0) begin
        wait_r <= wait_r - 1'b1;
      end
      case (seq_r)
        rps_pkg::SEQ_IDLE: begin
          if (start_req) begin
            pos_r <= 1'b1;
            wait_r <= 19'(STEP_CYC - 1);
            seq_r <= rps_pkg::SEQ_POS_UP;
          end
        end
        rps_pkg::SEQ_POS_UP: begin
          if (stop_req) begin
            seq_r <= rps_pkg::SEQ_LOAD_OFF;
          end else if (wait_r == 19'h0) begin
            neg_r <= 1'b1;
            wait_r <= 19'(STEP_CYC - 1);
            seq_r <= rps_pkg::SEQ_NEG_UP;
          end
        end
        rps_pkg::SEQ_NEG_UP: begin
          if (stop_req) begin
            seq_r <= rps_pkg::SEQ_LOAD_OFF;
          end else if (wait_r == 19'h0) begin
            load_r <= 1'b1;
            seq_r <= rps_pkg::SEQ_LOADED;
          end
        end
        rps_pkg::SEQ_LOADED: begin
          if (stop_req) begin
            load_r <= 1'b0;
            seq_r <= rps_pkg::SEQ_LOAD_OFF;
          end
        end
        rps_pkg::SEQ_LOAD_OFF: begin
          load_r <= 1'b0;
          pos_r <= 1'b0;
          neg_r <= 1'b0;
          wait_r <= 19'(GAP_CYC - 1);
          seq_r <= rps_pkg::SEQ_GAP;
        end
        rps_pkg::SEQ_GAP: begin
          if (wait_r == 19'h0) begin
            seq_r <= rps_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_r <= rps_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  assign ev[rps_pkg::IRQ_LOAD_READY_BIT] = seq_r == rps_pkg::SEQ_NEG_UP && !stop_req &&
                                           wait_r == 19'h0;
  assign ev[rps_pkg::IRQ_STOPPED_BIT] = seq_r == rps_pkg::SEQ_LOAD_OFF;
  assign ev[rps_pkg::IRQ_RESTART_OK_BIT] = seq_r == rps_pkg::SEQ_GAP && wait_r == 19'h0;

  // Sticky status; a read clears the bits it returned, a new event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (rd_irq ? (stat_r & ~prdata_r[IRQW-1:0]) : stat_r) | ev;
    end
  end

  logic irq_r;

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // Outputs, each straight from a flip-flop; enables always driven.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign panel_load_enable = load_r;
  assign rail.pos_en_drv = pos_r;
  assign rail.neg_en_drv = neg_r;
  assign rail.pos_en_oe = 1'b1;
  assign rail.neg_en_oe = 1'b1;

endmodule // rps_host
`default_nettype wire

/* testbench/rps_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_assertions #(
  parameter int STARTUP_CYC = 20,
  parameter int SC_CYC = 40,
  parameter int STEP_CYC = 30,
  parameter int GAP_CYC = 10
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals.
  input wire logic pos_en_drv,
  input wire logic neg_en_drv,
  input wire logic positive_rail_enable,
  input wire logic negative_rail_enable,
  // Device pins.
  input wire logic supply_input_low,
  input wire logic pos_at_target,
  input wire logic pos_below_sc,
  input wire logic neg_below_sc,
  input wire logic pos_rail_run,
  input wire logic neg_rail_run,
  input wire logic pos_discharge,
  input wire logic neg_discharge,
  input wire rps_pkg::rps_limit_e limit_mode,
  input wire logic shutdown_latched,
  // Host pin.
  input wire logic panel_load_enable
);
  int guard_cnt_r;
  int pos_sc_cnt_r;
  int neg_sc_cnt_r;
  int pos_on_cnt_r;
  int neg_on_cnt_r;
  int off_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Run lengths of guard mode, short conditions, enables and the idle gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_cnt_r <= 0;
      pos_sc_cnt_r <= 0;
      neg_sc_cnt_r <= 0;
      pos_on_cnt_r <= 0;
      neg_on_cnt_r <= 0;
      off_cnt_r <= GAP_CYC;
    end else begin
      guard_cnt_r <= (limit_mode == rps_pkg::LIM_GUARD) ? guard_cnt_r + 1 : 0;
      pos_sc_cnt_r <= (positive_rail_enable && pos_below_sc && !supply_input_low) ?
                      pos_sc_cnt_r + 1 : 0;
      neg_sc_cnt_r <= (negative_rail_enable && neg_below_sc && !supply_input_low) ?
                      neg_sc_cnt_r + 1 : 0;
      pos_on_cnt_r <= pos_en_drv ? pos_on_cnt_r + 1 : 0;
      neg_on_cnt_r <= neg_en_drv ? neg_on_cnt_r + 1 : 0;
      off_cnt_r <= (pos_en_drv || neg_en_drv) ? 0 : off_cnt_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // All checks share the one clock and reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_POS_DISCHARGE: assert property (!positive_rail_enable [*4] |-> pos_discharge)
    else $error("positive discharge off while enable low");
  AST_NEG_DISCHARGE: assert property (!negative_rail_enable [*4] |-> neg_discharge)
    else $error("negative discharge off while enable low");
  AST_POS_RUN: assert property (pos_rail_run |-> $past(positive_rail_enable, 3))
    else $error("positive rail on without enable");
  AST_NEG_RUN: assert property (neg_rail_run |-> $past(negative_rail_enable, 3))
    else $error("negative rail on without its own enable");
  AST_GUARD_LEN: assert property (($past(limit_mode) == rps_pkg::LIM_GUARD &&
    limit_mode inside {rps_pkg::LIM_FALLBACK, rps_pkg::LIM_BOOST}) |-> guard_cnt_r == STARTUP_CYC)
    else $error("guard window length wrong");
  AST_FALLBACK_IN: assert property ((!pos_at_target) [*4] ##0 (pos_rail_run &&
    $past(limit_mode) == rps_pkg::LIM_GUARD && limit_mode != rps_pkg::LIM_GUARD)
    |-> limit_mode == rps_pkg::LIM_FALLBACK) else $error("fallback limit not entered");
  AST_FALLBACK_OUT: assert property (pos_at_target [*4] |-> limit_mode != rps_pkg::LIM_FALLBACK)
    else $error("fallback kept at target");
  AST_SUPPLY_CLEAR: assert property (supply_input_low [*4] |->
    limit_mode == rps_pkg::LIM_OFF && !pos_rail_run && !shutdown_latched)
    else $error("state kept during supply collapse");
  AST_SC_BOUND: assert property ((pos_sc_cnt_r == SC_CYC + 8 || neg_sc_cnt_r == SC_CYC + 8)
    |-> shutdown_latched) else $error("short held but no latch");
  AST_SC_CAUSE: assert property ($rose(shutdown_latched) |->
    pos_sc_cnt_r >= SC_CYC || neg_sc_cnt_r >= SC_CYC) else $error("latch before full count");
  AST_LATCH_RUN: assert property (shutdown_latched [*2] |-> !pos_rail_run && !neg_rail_run)
    else $error("rail runs while latched");
  AST_LATCH_CLEAR: assert property ((!positive_rail_enable && !negative_rail_enable) [*8]
    |-> !shutdown_latched) else $error("latch kept with enables low");
  AST_NEG_STEP: assert property ($rose(neg_en_drv) |-> pos_on_cnt_r == STEP_CYC)
    else $error("negative enable step wrong");
  AST_LOAD_STEP: assert property ($rose(panel_load_enable) |-> neg_on_cnt_r >= STEP_CYC)
    else $error("load started early");
  AST_GAP: assert property ($rose(pos_en_drv) |-> off_cnt_r >= GAP_CYC)
    else $error("restart gap too short");
  AST_LOAD_FIRST: assert property ($fell(pos_en_drv) |-> !panel_load_enable)
    else $error("enables dropped before load stop");
endmodule // rps_assertions
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STARTUP_CYC = 20;
  localparam int SC_CYC = 40;
  localparam int STEP_CYC = 30;
  localparam int GAP_CYC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, panel_load_enable, err;
  logic supply_input_low = 1'b0, pos_at_target = 1'b0, pos_below_sc = 1'b0, neg_below_sc = 1'b0;
  logic pos_rail_run, neg_rail_run, pos_discharge, neg_discharge, shutdown_latched;
  logic pos_sc_fault, neg_sc_fault, pos_sc_counting;
  rps_pkg::rps_limit_e limit_mode;
  int mismatches = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, link and the two ends.
  always #12.5 pclk = ~pclk;
  rps_rail_if u_rps_rail_if ();
  rps_host #(.STEP_CYC(STEP_CYC), .GAP_CYC(GAP_CYC)) u_rps_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .panel_load_enable(panel_load_enable), .rail(u_rps_rail_if.host));
  rps_device #(.STARTUP_CYC(STARTUP_CYC), .SC_CYC(SC_CYC)) u_rps_device (.pclk(pclk),
    .presetn(presetn), .rail(u_rps_rail_if.device), .supply_input_low(supply_input_low),
    .pos_at_target(pos_at_target), .pos_below_sc(pos_below_sc), .neg_below_sc(neg_below_sc),
    .pos_rail_run(pos_rail_run), .neg_rail_run(neg_rail_run), .pos_discharge(pos_discharge),
    .neg_discharge(neg_discharge), .limit_mode(limit_mode), .pos_sc_counting(pos_sc_counting),
    .neg_sc_counting(), .pos_sc_fault(pos_sc_fault), .neg_sc_fault(neg_sc_fault),
    .shutdown_latched(shutdown_latched));
  rps_assertions #(.STARTUP_CYC(STARTUP_CYC), .SC_CYC(SC_CYC), .STEP_CYC(STEP_CYC),
    .GAP_CYC(GAP_CYC)) u_rps_assertions (.pclk(pclk), .presetn(presetn),
    .pos_en_drv(u_rps_rail_if.pos_en_drv), .neg_en_drv(u_rps_rail_if.neg_en_drv),
    .positive_rail_enable(u_rps_rail_if.positive_rail_enable),
    .negative_rail_enable(u_rps_rail_if.negative_rail_enable),
    .supply_input_low(supply_input_low), .pos_at_target(pos_at_target),
    .pos_below_sc(pos_below_sc), .neg_below_sc(neg_below_sc), .pos_rail_run(pos_rail_run),
    .neg_rail_run(neg_rail_run), .pos_discharge(pos_discharge), .neg_discharge(neg_discharge),
    .limit_mode(limit_mode), .shutdown_latched(shutdown_latched),
    .panel_load_enable(panel_load_enable));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycle and closing tasks.
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic close_out;
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    chk("discharge", 32'({pos_discharge, neg_discharge}), 32'h3);
    chk("limit", 32'(limit_mode), 32'(rps_pkg::LIM_OFF));
    apb(rps_pkg::REG_IRQ_MASK, 1'b0, 32'h0);
    chk("mask", rd, 32'(rps_pkg::IRQ_MASK_RST));
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
  endtask

  task automatic t_start;
    pos_at_target <= 1'b1;
    apb(rps_pkg::REG_IRQ_MASK, 1'b1, 32'h7);
    apb(rps_pkg::REG_CTRL, 1'b1, 32'h1);
    for (int i = 0; i < 50 && pos_rail_run !== 1'b1; i++) @(posedge pclk);
    chk("neg run", 32'(neg_rail_run), 32'h0);
    chk("pos discharge", 32'(pos_discharge), 32'h0);
    repeat (STARTUP_CYC + 5) @(posedge pclk);
    chk("limit", 32'(limit_mode), 32'(rps_pkg::LIM_BOOST));
    for (int i = 0; i < 200 && panel_load_enable !== 1'b1; i++) @(posedge pclk);
    chk("neg run", 32'(neg_rail_run), 32'h1);
    @(posedge pclk);
    chk("irq", 32'(irq), 32'h1);
    apb(rps_pkg::REG_IRQ_STATUS, 1'b0, 32'h0);
    chk("irq status", rd, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'h0);
  endtask

  task automatic t_short;
    pos_below_sc <= 1'b1;
    repeat (SC_CYC / 2) @(posedge pclk);
    chk("counting", 32'(pos_sc_counting), 32'h1);
    pos_below_sc <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("recovered", 32'({shutdown_latched, pos_rail_run}), 32'h1);
    neg_below_sc <= 1'b1;
    for (int i = 0; i < 200 && shutdown_latched !== 1'b1; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("latched", 32'({pos_rail_run, neg_rail_run, neg_sc_fault}), 32'h1);
    neg_below_sc <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("held", 32'(shutdown_latched), 32'h1);
  endtask

  task automatic t_stop;
    apb(rps_pkg::REG_CTRL, 1'b1, 32'h2);
    for (int i = 0; i < 100 && shutdown_latched !== 1'b0; i++) @(posedge pclk);
    chk("cleared", 32'({shutdown_latched, pos_sc_fault, neg_sc_fault}), 32'h0);
    chk("load", 32'(panel_load_enable), 32'h0);
    chk("discharge", 32'({pos_discharge, neg_discharge}), 32'h3);
    repeat (GAP_CYC + 10) @(posedge pclk);
    apb(rps_pkg::REG_IRQ_STATUS, 1'b0, 32'h0);
    chk("stop events", rd, 32'h6);
    apb(rps_pkg::REG_STATUS, 1'b0, 32'h0);
    chk("seq idle", 32'(rd[2:0]), 32'h0);
  endtask

  task automatic t_fallback;
    pos_at_target <= 1'b0;
    apb(rps_pkg::REG_CTRL, 1'b1, 32'h1);
    for (int i = 0; i < 50 && pos_rail_run !== 1'b1; i++) @(posedge pclk);
    repeat (STARTUP_CYC + 5) @(posedge pclk);
    chk("limit", 32'(limit_mode), 32'(rps_pkg::LIM_FALLBACK));
    pos_at_target <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("limit", 32'(limit_mode), 32'(rps_pkg::LIM_BOOST));
  endtask

  task automatic t_supply;
    supply_input_low <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("collapse", 32'({pos_rail_run, limit_mode}), 32'(rps_pkg::LIM_OFF));
    supply_input_low <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_short();
    t_stop();
    t_fallback();
    t_supply();
    close_out();
  end

  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
